// ===== verif/twb_ctrl_tb.sv
/*
  Self-checking bench: register access, slave address match, master start
  and division clock timing. Assumes the peer model and pull-ups on all lines.
*/
`timescale 1ns/1ps
module twb_ctrl_tb;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [2:0] scl_out, scl_oe, sda_out, sda_oe, scl_pull, sda_pull;
  wire logic [2:0] scl_ln = ~(scl_oe | scl_pull);
  wire logic [2:0] sda_ln = ~(sda_oe | sda_pull);
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;

  always #12.5 core_clk = ~core_clk;

  twb_ctrl #(.NCH(3)) u_twb_ctrl (.core_clk(core_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .scl_in(scl_ln), .sda_in(sda_ln),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe));
  twb_peer u_twb_peer (.core_clk(core_clk), .scl(scl_ln), .sda(sda_ln), .scl_pull(scl_pull),
    .sda_pull(sda_pull));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic finish_test();
    if (num_errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      finish_test();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Single word transfer; waits on hready in both phases
  task automatic bus(input logic wr, input logic [31:0] idx, input logic [7:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {idx[29:0], 2'b00};
    hwrite <= wr;
    do @(posedge core_clk); while (hreadyout !== 1'b1 && ++n < 50);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    do @(posedge core_clk); while (hreadyout !== 1'b1 && ++n < 50);
    rd = hrdata;
    if (n >= 50)
      num_errors++;
  endtask

  task automatic wr(input logic [31:0] idx, input logic [7:0] d);
    logic [31:0] x;
    bus(1'b1, idx, d, x);
  endtask

  task automatic rd(input logic [31:0] idx, output logic [31:0] x);
    bus(1'b0, idx, 8'h00, x);
  endtask

  task automatic rd_chk(input string what, input logic [31:0] idx, input logic [7:0] exp);
    logic [31:0] x;
    rd(idx, x);
    chk(what, {24'h0, exp}, x);
  endtask

  // Edges until the clock line reaches a level
  task automatic wait_scl(input int ch, input logic v, output int n);
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (scl_ln[ch] !== v && n < 3000);
    if (n >= 3000)
      num_errors++;
  endtask

  task automatic do_reset();
    srst <= 1'b1;
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
  endtask

  function automatic logic [31:0] sbase(input int ch);
    return twb_pkg::IDX_SHIFT_CH0 + 32'(ch * 16);
  endfunction

  // Cycles per division tick; zero when stopped or prohibited
  function automatic int tick_len(input logic [7:0] p);
    if (!p[4] || (p[3] && p[1:0] != 2'b00))
      return 0;
    return p[3] ? 1 : int'(p[1:0]) + 2;
  endfunction

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [31:0] x;
    logic [7:0] b, d, own, got;
    logic ack;
    int n, c, ch;
    void'($urandom(66718));
    do_reset();
    for (ch = 0; ch < 3; ch++)
    begin
      rd_chk("shift", sbase(ch), 8'h00);
      rd_chk("own", sbase(ch) + 3, 8'h00);
      own = {7'($urandom()), 1'b0};
      wr(sbase(ch) + 3, own);
      rd_chk("own", sbase(ch) + 3, own);
    end
    for (c = 0; c < 2; c++)
    begin
      rd_chk("presc", twb_pkg::IDX_PRESC_A + 32'(4 * c), 8'h00);
      b = $urandom();
      wr(twb_pkg::IDX_PRESC_A + 32'(4 * c), b);
      rd_chk("presc", twb_pkg::IDX_PRESC_A + 32'(4 * c), b & twb_pkg::PRESC_MASK);
    end
    wr(32'h100, 8'hA5);
    rd_chk("unmapped", 32'h100, 8'h00);

    // Slave passes: three matches, then a mismatch on channel 0
    do_reset();
    for (ch = 0; ch < 4; ch++)
    begin
      c = ch % 3;
      own = {7'($urandom()), 1'b0};
      wr(sbase(c) + 3, own);
      wr(sbase(c) + 2, 8'h01);
      b = {own[7:1], 1'($urandom())};
      if (ch == 3)
        b[$urandom_range(7, 1)] ^= 1'b1;
      u_twb_peer.start(c);
      rd(sbase(c) + 1, x);
      chk("status", 32'h1, x & 32'h7);
      u_twb_peer.send(c, b, ack);
      chk("ack", 32'(ch != 3), 32'(ack));
      repeat (4) @(posedge core_clk);
      rd(sbase(c) + 1, x);
      chk("status", (ch == 3) ? 32'h1 : 32'hD, x & 32'hF);
      if (ch != 3)
      begin
        rd_chk("shift", sbase(c), b);
        chk("scl hold", 32'h1, 32'(scl_oe[c]));
        wr(sbase(c), 8'hFF);
        repeat (2) @(posedge core_clk);
        chk("scl hold", 32'h0, 32'(scl_oe[c]));
      end
      u_twb_peer.stop(c);
      rd(sbase(c) + 1, x);
      chk("status", 32'h2, x & 32'h7);
    end

    // Master start and division clock per code; other select left stopped
    for (c = 0; c < 7; c++)
    begin
      ch = c % 3;
      b = (c < 4) ? (8'h10 | 8'(c)) : (c == 4) ? 8'h18 : (c == 5) ? 8'h03 : 8'h1D;
      do_reset();
      wr(twb_pkg::IDX_PRESC_A, (ch == 0) ? b : 8'h00);
      wr(twb_pkg::IDX_PRESC_B, (ch == 0) ? 8'h00 : b);
      wr(sbase(ch) + 2, 8'h01);
      if (c == 0)
      begin
        wr(sbase(ch) + 2, 8'h03);
        repeat (20) @(posedge core_clk);
        chk("early start", 32'h0, 32'(sda_oe[ch]));
        wr(sbase(ch) + 2, 8'h01);
      end
      u_twb_peer.stop(ch);
      wr(sbase(ch) + 2, 8'h03);
      d = $urandom();
      wr(sbase(ch), d);
      if (tick_len(b) == 0)
      begin
        repeat (200) @(posedge core_clk);
        chk("stalled clock", 32'h0, 32'(scl_oe[ch]));
      end
      else
      begin
        wait_scl(ch, 1'b0, n);
        chk("start data", 32'h0, 32'(sda_ln[ch]));
        for (int i = 7; i >= 0; i--)
        begin
          wait_scl(ch, 1'b1, n);
          got[i] = sda_ln[ch];
          wait_scl(ch, 1'b0, n);
          if (i == 7)
            chk("tick", 32'(tick_len(b)), 32'(n));
        end
        chk("byte", {24'h0, d}, {24'h0, got});
      end
    end
    chk("open drain", 32'h0, 32'({scl_out, sda_out, hresp}));
    finish_test();
  end
endmodule

// ===== verif/twb_peer.sv
/*
  Behavioural bus master standing on the far side of each channel's line pair.
  Assumes the bench resolves every line as a wired-AND with a pull-up.
*/
`timescale 1ns/1ps
module twb_peer #(
  parameter int HALF = 8
) (
  input wire logic core_clk, // bench clock
  input wire logic [2:0] scl, // resolved clock lines
  input wire logic [2:0] sda, // resolved data lines
  output logic [2:0] scl_pull, // pull clock low
  output logic [2:0] sda_pull // pull data low
);
  initial
  begin
    scl_pull = 3'h0;
    sda_pull = 3'h0;
  end

  task automatic half();
    repeat (HALF) @(posedge core_clk);
  endtask

  // Release the clock, then wait (bounded) while a slave stretches it
  task automatic rise(input int ch);
    int n;
    n = 0;
    scl_pull[ch] <= 1'b0;
    do @(posedge core_clk); while (scl[ch] !== 1'b1 && ++n < 5000);
    half();
  endtask

  task automatic start(input int ch);
    sda_pull[ch] <= 1'b1;
    half();
    scl_pull[ch] <= 1'b1;
    half();
  endtask

  task automatic stop(input int ch);
    scl_pull[ch] <= 1'b1;
    half();
    sda_pull[ch] <= 1'b1;
    half();
    rise(ch);
    sda_pull[ch] <= 1'b0;
    half();
  endtask

  // Eight bits MSB first, then a released ninth bit for the receiver's answer
  task automatic send(input int ch, input logic [7:0] b, output logic ack);
    for (int i = 8; i >= 0; i--)
    begin
      sda_pull[ch] <= (i > 0) ? ~b[i-1] : 1'b0;
      half();
      rise(ch);
      ack = ~sda[ch];
      scl_pull[ch] <= 1'b1;
      // Data never moves in the same cycle as the clock edge
      @(posedge core_clk);
    end
  endtask
endmodule

// ===== verilog/twb_ctrl.sv
/*
  Three-channel two-wire bus controller: AHB-Lite register slave, shared
  division clock selects, per-channel start/stop detection, address match,
  byte shifting with wait-state hold, and master start/stop generation.
  Assumes synchronous pad inputs and external pull-ups on both lines.
*/
`timescale 1ns/1ps

module twb_ctrl #(
  parameter int NCH = twb_pkg::NCH
) (
  input wire logic core_clk, // 40 MHz clock
  input wire logic srst, // synchronous reset
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // word transfers only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // slave ready
  output logic hresp, // always OKAY
  input wire logic [NCH-1:0] scl_in, // clock line level
  input wire logic [NCH-1:0] sda_in, // data line level
  output logic [NCH-1:0] scl_out, // clock pad value
  output logic [NCH-1:0] scl_oe, // clock pulled low
  output logic [NCH-1:0] sda_out, // data pad value
  output logic [NCH-1:0] sda_oe // data pulled low
);

  if (NCH != 3)
  begin : g_bad_nch
    $error("twb_ctrl serves exactly three channels");
  end

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic [7:0] presc_a;
  logic [7:0] presc_b;
  logic d_wr;
  logic rd1;
  logic [11:0] d_idx;
  logic [7:0] rd_mux;
  logic [7:0] ch_rd [NCH];
  wire logic a_take = hsel && htrans[1] && hready;
  wire logic hit_pa = d_idx == twb_pkg::IDX_PRESC_A[11:0];
  wire logic hit_pb = d_idx == twb_pkg::IDX_PRESC_B[11:0];

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      d_wr <= 1'b0;
      rd1 <= 1'b0;
      d_idx <= 12'h000;
    end
    else
    begin
      d_wr <= a_take && hwrite;
      rd1 <= a_take && !hwrite;
      if (a_take)
        d_idx <= haddr[13:2];
    end
  end

  // One wait state on reads so data written just before is seen
  assign hreadyout = !rd1;
  assign hresp = 1'b0;

  always_comb
  begin
    rd_mux = hit_pa ? presc_a : hit_pb ? presc_b : 8'h00;
    for (int k = 0; k < NCH; k++)
      rd_mux = rd_mux | ch_rd[k];
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      hrdata <= 32'h0000_0000;
    else if (rd1)
      hrdata <= {24'h00_0000, rd_mux};
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      presc_a <= twb_pkg::REG_RESET;
      presc_b <= twb_pkg::REG_RESET;
    end
    else if (d_wr && hit_pa)
      presc_a <= hwdata[7:0] & twb_pkg::PRESC_MASK;
    else if (d_wr && hit_pb)
      presc_b <= hwdata[7:0] & twb_pkg::PRESC_MASK;
  end

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  assign scl_out = {NCH{1'b0}};
  assign sda_out = {NCH{1'b0}};

  for (genvar i = 0; i < NCH; i++)
  begin : g_ch
    localparam logic [31:0] SIDX = (i == 0) ? twb_pkg::IDX_SHIFT_CH0 :
      (i == 1) ? twb_pkg::IDX_SHIFT_CH1 : twb_pkg::IDX_SHIFT_CH2;
    localparam logic [31:0] OIDX = (i == 0) ? twb_pkg::IDX_OWN_CH0 :
      (i == 1) ? twb_pkg::IDX_OWN_CH1 : twb_pkg::IDX_OWN_CH2;
    logic [7:0] shift;
    logic [7:0] own;
    twb_pkg::ctl_s ctl;
    twb_pkg::sts_s sts;
    wire logic hit_s = d_idx == SIDX[11:0];
    wire logic hit_o = d_idx == OIDX[11:0];
    wire logic hit_t = d_idx == SIDX[11:0] + twb_pkg::SUB_STAT;
    wire logic hit_c = d_idx == SIDX[11:0] + twb_pkg::SUB_CTRL;
    wire logic [7:0] presc = (i == 0) ? presc_a : presc_b;

    assign ch_rd[i] = hit_s ? shift : hit_o ? own : hit_c ? ctl : hit_t ? sts : 8'h00;

    twb_channel u_ch (
      .core_clk(core_clk),
      .srst(srst),
      .presc(presc),
      .scl_in(scl_in[i]),
      .sda_in(sda_in[i]),
      .wr_shift(d_wr && hit_s),
      .wr_ctl(d_wr && hit_c),
      .wr_own(d_wr && hit_o),
      .wdata(hwdata[7:0]),
      .shift(shift),
      .own(own),
      .ctl(ctl),
      .sts(sts),
      .scl_oe(scl_oe[i]),
      .sda_oe(sda_oe[i])
    );
  end

endmodule

module twb_channel (
  input wire logic core_clk, // 40 MHz clock
  input wire logic srst, // synchronous reset
  input wire logic [7:0] presc, // division clock select
  input wire logic scl_in, // clock line level
  input wire logic sda_in, // data line level
  input wire logic wr_shift, // shift register write
  input wire logic wr_ctl, // control write
  input wire logic wr_own, // own-address write
  input wire logic [7:0] wdata, // write byte
  output logic [7:0] shift, // shift register
  output logic [7:0] own, // own-address register
  output twb_pkg::ctl_s ctl, // control register
  output twb_pkg::sts_s sts, // status view
  output logic scl_oe, // pull clock low
  output logic sda_oe // pull data low
);

  twb_pkg::state_e st;
  logic scl_q;
  logic sda_q;
  logic std;
  logic spd;
  logic sel;
  logic tx;
  logic master;
  logic addr_ph;
  logic pend;
  logic [3:0] bitcnt;
  logic [2:0] divcnt;

  // ----------------------------------------------------------------
  // Division clock and line events
  // ----------------------------------------------------------------
  wire logic [2:0] dlen = twb_pkg::div_len({presc[twb_pkg::DIV_HI_BIT], presc[1:0]});
  wire logic div_on = presc[twb_pkg::DIV_EN_BIT] && (dlen != 3'h0);
  wire logic tick = div_on && (divcnt == dlen - 3'h1);
  wire logic en = ctl.bus_enable_bit;
  wire logic scl_rise = en && scl_in && !scl_q;
  wire logic scl_fall = en && !scl_in && scl_q;
  wire logic start_ev = en && scl_in && scl_q && sda_q && !sda_in;
  wire logic stop_ev = en && scl_in && scl_q && !sda_q && sda_in;
  wire logic addr_hit = shift[7:1] == own[7:1];
  wire logic can_start = en && ctl.start_trigger_bit && spd && (st == twb_pkg::ST_IDLE);
  wire logic in_wait = st == twb_pkg::ST_WAIT;
  wire logic rel_req = wr_ctl && wdata[2];
  wire logic resume = in_wait && (wr_shift || rel_req);
  wire logic m_clk = master && tick && (st == twb_pkg::ST_SHIFT || st == twb_pkg::ST_ACK);

  assign sts = {2'b00, master, tx, in_wait, sel, spd, std};

  always_ff @(posedge core_clk)
  begin
    if (srst || !div_on || tick)
      divcnt <= 3'h0;
    else
      divcnt <= divcnt + 3'h1;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  // ----------------------------------------------------------------
  // Registers and flags
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (srst)
      own <= twb_pkg::REG_RESET;
    else if (wr_own)
      own <= wdata;
  end

  // A software write wins over the hardware self-clear of the triggers
  always_ff @(posedge core_clk)
  begin
    if (srst)
      ctl <= twb_pkg::REG_RESET;
    else if (wr_ctl)
      ctl <= {4'h0, wdata[3], 1'b0, wdata[1:0]};
    else
    begin
      if (can_start)
        ctl.start_trigger_bit <= 1'b0;
      if (st == twb_pkg::ST_STOP)
        ctl.stop_trigger <= 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      std <= 1'b0;
      spd <= 1'b0;
    end
    else if (start_ev)
    begin
      std <= 1'b1;
      spd <= 1'b0;
    end
    else if (stop_ev)
    begin
      spd <= 1'b1;
      std <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Protocol engine
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      st <= twb_pkg::ST_IDLE;
      shift <= twb_pkg::REG_RESET;
      sel <= 1'b0;
      tx <= 1'b0;
      master <= 1'b0;
      addr_ph <= 1'b0;
      pend <= 1'b0;
      bitcnt <= 4'h0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end
    else if (!en || stop_ev)
    begin
      st <= twb_pkg::ST_IDLE;
      sel <= 1'b0;
      master <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end
    else if (start_ev && !master)
    begin
      st <= twb_pkg::ST_SHIFT;
      addr_ph <= 1'b1;
      bitcnt <= 4'h0;
      sel <= 1'b0;
      tx <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end
    else
    begin
      // Release, then pull low only once the line is really high
      if (m_clk)
      begin
        if (scl_oe)
          scl_oe <= 1'b0;
        else if (scl_in)
          scl_oe <= 1'b1;
      end
      case (st)
        twb_pkg::ST_IDLE:
        begin
          if (can_start)
          begin
            st <= twb_pkg::ST_START;
            master <= 1'b1;
            sda_oe <= 1'b1;
            pend <= 1'b0;
            addr_ph <= 1'b1;
          end
        end
        twb_pkg::ST_START:
        begin
          if (wr_shift)
          begin
            shift <= wdata;
            pend <= 1'b1;
          end
          if (tick)
          begin
            scl_oe <= 1'b1;
            bitcnt <= 4'h0;
            tx <= 1'b1;
            if (pend || wr_shift)
            begin
              st <= twb_pkg::ST_SHIFT;
              // Keep data low; first bit follows once the clock is seen low
              sda_oe <= 1'b1;
            end
            else
              st <= twb_pkg::ST_WAIT;
          end
        end
        twb_pkg::ST_SHIFT:
        begin
          if (scl_rise)
          begin
            shift <= {shift[6:0], sda_in};
            bitcnt <= bitcnt + 4'h1;
          end
          if (scl_fall && bitcnt == twb_pkg::BITS_PER_BYTE)
          begin
            st <= twb_pkg::ST_ACK;
            if (addr_ph && !master)
            begin
              sel <= addr_hit;
              tx <= shift[0];
              sda_oe <= addr_hit;
              if (!addr_hit)
                st <= twb_pkg::ST_IDLE;
            end
            else if (addr_ph)
            begin
              tx <= !shift[0];
              sda_oe <= 1'b0;
            end
            else
              sda_oe <= !tx;
          end
          else if (scl_fall)
            sda_oe <= tx && !shift[7];
        end
        twb_pkg::ST_ACK:
        begin
          if (scl_rise)
            bitcnt <= bitcnt + 4'h1;
          if (scl_fall)
          begin
            st <= twb_pkg::ST_WAIT;
            sda_oe <= 1'b0;
            addr_ph <= 1'b0;
            scl_oe <= 1'b1;
          end
        end
        twb_pkg::ST_WAIT:
        begin
          if (resume)
          begin
            st <= twb_pkg::ST_SHIFT;
            bitcnt <= 4'h0;
            scl_oe <= master;
            sda_oe <= wr_shift && tx && !wdata[7];
            if (wr_shift)
              shift <= wdata;
          end
          else if (master && ctl.stop_trigger)
          begin
            st <= twb_pkg::ST_STOP;
            sda_oe <= 1'b1;
          end
        end
        twb_pkg::ST_STOP:
        begin
          if (tick && scl_oe)
            scl_oe <= 1'b0;
          else if (tick && scl_in)
            sda_oe <= 1'b0;
        end
        default:
          st <= twb_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  sequence addr_seen;
    st == twb_pkg::ST_SHIFT && addr_ph && !master && scl_fall && bitcnt == 4'h8;
  endsequence

  start_flag_a: assert property (start_ev |=> sts.start_detected_flag)
    else $error("start not flagged");
  stop_flag_a: assert property (stop_ev |=> spd && !std)
    else $error("stop not flagged");
  div_off_a: assert property (!presc[twb_pkg::DIV_EN_BIT] |-> !tick)
    else $error("division clock runs while disabled");
  div_rate_a: assert property (tick && $past(tick) |-> $past(dlen) == 3'h1)
    else $error("back to back ticks without bypass");
  start_gate_a: assert property ($rose(master) |-> $past(spd) && $past(ctl.start_trigger_bit))
    else $error("start issued without stop detected");
  wait_free_a: assert property (in_wait && en && wr_shift && !master |=> !scl_oe && st == twb_pkg::ST_SHIFT)
    else $error("wait not released by write");
  wait_hold_a: assert property (in_wait |-> scl_oe)
    else $error("clock not held in wait");
  addr_match_a: assert property (addr_seen ##0 addr_hit |=> sel && sda_oe ##1 st != twb_pkg::ST_IDLE)
    else $error("matching address not acknowledged");
  addr_miss_a: assert property (addr_seen ##0 !addr_hit |=> st == twb_pkg::ST_IDLE && !sda_oe)
    else $error("foreign address not ignored");

endmodule

// ===== verilog/twb_pkg.sv
/*
  Constants, register layouts and state codes for the two-wire bus controller.
  Assumes a 32-bit AHB-Lite register bus, three channels and open-drain pads outside.
*/
package twb_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam int NCH = 3;
  localparam logic [31:0] IDX_SHIFT_CH0 = 32'h0FFF_FD80;
  localparam logic [31:0] IDX_SHIFT_CH1 = 32'h0FFF_FD90;
  localparam logic [31:0] IDX_SHIFT_CH2 = 32'h0FFF_FDA0;
  localparam logic [31:0] IDX_PRESC_A = 32'hFFFF_F340;
  localparam logic [31:0] IDX_PRESC_B = 32'hFFFF_F344;
  localparam logic [31:0] IDX_OWN_CH0 = 32'hFFFF_FD83;
  localparam logic [31:0] IDX_OWN_CH1 = 32'hFFFF_FD93;
  localparam logic [31:0] IDX_OWN_CH2 = 32'hFFFF_FDA3;
  // Status and control sit beside each channel's shift register
  localparam logic [11:0] SUB_STAT = 12'h001;
  localparam logic [11:0] SUB_CTRL = 12'h002;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] PRESC_MASK = 8'h1B;
  localparam int DIV_EN_BIT = 4;
  localparam int DIV_HI_BIT = 3;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef struct packed {
    logic [3:0] pad;
    logic stop_trigger;
    logic wait_release;
    logic start_trigger_bit;
    logic bus_enable_bit;
  } ctl_s;

  typedef struct packed {
    logic [1:0] pad;
    logic is_master;
    logic transmitting;
    logic waiting;
    logic selected;
    logic stop_detected_flag;
    logic start_detected_flag;
  } sts_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_SHIFT = 3'b010,
    ST_ACK = 3'b011,
    ST_WAIT = 3'b100,
    ST_STOP = 3'b101
  } state_e;

  // Cycles per division clock tick; zero means a prohibited code
  function automatic logic [2:0] div_len(input logic [2:0] code);
    case (code)
      3'h0: div_len = 3'h2;
      3'h1: div_len = 3'h3;
      3'h2: div_len = 3'h4;
      3'h3: div_len = 3'h5;
      3'h4: div_len = 3'h1;
      default: div_len = 3'h0;
    endcase
  endfunction

endpackage
